// [rtl/irq_ctrl.sv]
// two-level vectored interrupt controller with apb register slave
`timescale 1ns/1ps
module irq_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [14:0] src_pend,
  input wire logic instr_done,
  input wire logic return_from_isr,
  output logic call_busy,
  output logic isr_entry,
  output logic [15:0] vector_addr,
  output logic [14:0] pend_clear,
  output logic [1:0] active_level,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] en;
    logic [6:0] lvl;
    logic [7:0] xen;
    logic [7:0] xlvl;
    logic [2:0] sts;
    logic [2:0] msk;
    logic cand_v;
    logic cand_hi;
    logic [3:0] cand_idx;
    irq_ctrl_pkg::seq_state_t st;
    logic [1:0] cnt;
    logic act_lo;
    logic act_hi;
    logic [15:0] vec;
    logic entry;
    logic [14:0] clr;
    logic [31:0] rdata;
    logic slverr;
  } ctrl_state_t;

  ctrl_state_t cur_r;
  ctrl_state_t cur_nxt;

  // ---------------------------------------------------------------
  // source vectors
  // ---------------------------------------------------------------
  logic [14:0] en_vec;
  logic [14:0] lvl_vec;
  logic [14:0] elig;
  logic [14:0] elig_hi;
  logic [14:0] elig_lo;
  logic hi_ok;
  logic lo_ok;
  logic hi_v;
  logic lo_v;
  logic [3:0] hi_idx;
  logic [3:0] lo_idx;
  logic start;
  logic [14:0] sel_set;
  logic [14:0] lo_mask;

  // low seven sources on the primary pair, the rest on the extended pair
  assign en_vec = {cur_r.xen & irq_ctrl_pkg::XRSVD_MASK, cur_r.en[6:0]};
  assign lvl_vec = {cur_r.xlvl & irq_ctrl_pkg::XRSVD_MASK, cur_r.lvl};
  // global bit gates everything, whatever the per-source bits hold
  assign elig = src_pend & en_vec & {15{cur_r.en[irq_ctrl_pkg::GLOBAL_BIT]}};
  assign elig_hi = elig & lvl_vec;
  assign elig_lo = elig & ~lvl_vec;
  // a return frees its level at once, so only one instruction follows before the call
  assign hi_ok = !cur_r.act_hi || return_from_isr;
  assign lo_ok = !cur_r.act_hi && (!cur_r.act_lo || return_from_isr);

  prio_pick #(
    .W(irq_ctrl_pkg::NUM_SRC)
  ) u_pick_hi (
    .req(elig_hi),
    .valid(hi_v),
    .idx(hi_idx)
  );

  prio_pick #(
    .W(irq_ctrl_pkg::NUM_SRC)
  ) u_pick_lo (
    .req(elig_lo),
    .valid(lo_v),
    .idx(lo_idx)
  );

  // a call starts only at an instruction boundary that is not the return itself,
  // so exactly one more instruction runs after a return before the call
  assign start = (cur_r.st == irq_ctrl_pkg::ST_IDLE) && cur_r.cand_v && instr_done &&
                 !return_from_isr && cur_r.en[irq_ctrl_pkg::GLOBAL_BIT];

  assign sel_set = cur_r.cand_hi ? elig_hi : elig_lo;
  assign lo_mask = (15'h0001 << cur_r.cand_idx) - 15'h0001;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic wr_acc;
  logic [2:0] sts_set;

  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    cur_nxt = cur_r;
    sts_set = 3'h0;
    cur_nxt.entry = 1'b0;
    cur_nxt.clr = 15'h0000;

    // decode every clock; high level first, then fixed order
    if (hi_v && hi_ok) begin
      cur_nxt.cand_v = 1'b1;
      cur_nxt.cand_hi = 1'b1;
      cur_nxt.cand_idx = hi_idx;
    end else if (lo_v && lo_ok) begin
      cur_nxt.cand_v = 1'b1;
      cur_nxt.cand_hi = 1'b0;
      cur_nxt.cand_idx = lo_idx;
    end else begin
      cur_nxt.cand_v = 1'b0;
      cur_nxt.cand_hi = 1'b0;
      cur_nxt.cand_idx = 4'h0;
    end

    case (cur_r.st)
      irq_ctrl_pkg::ST_IDLE: begin
        if (start) begin
          cur_nxt.st = irq_ctrl_pkg::ST_CALL;
          cur_nxt.cnt = 2'h0;
          cur_nxt.vec = irq_ctrl_pkg::VEC_BASE + {9'h000, cur_r.cand_idx, 3'h0};
          if (cur_r.cand_idx <= irq_ctrl_pkg::AUTO_CLR_LAST) begin
            cur_nxt.clr = 15'h0001 << cur_r.cand_idx;
          end
          if (cur_r.cand_hi) begin
            cur_nxt.act_hi = 1'b1;
          end else begin
            cur_nxt.act_lo = 1'b1;
          end
          if (cur_r.act_lo) begin
            sts_set[irq_ctrl_pkg::STS_PREEMPT] = 1'b1;
          end
        end
      end
      irq_ctrl_pkg::ST_CALL: begin
        // four clocks of call after the detect clock
        cur_nxt.cnt = cur_r.cnt + 2'h1;
        if (cur_r.cnt == irq_ctrl_pkg::ENTRY_SET) begin
          cur_nxt.entry = 1'b1;
          sts_set[irq_ctrl_pkg::STS_ENTRY] = 1'b1;
        end
        if (cur_r.cnt == irq_ctrl_pkg::CALL_LAST) begin
          cur_nxt.st = irq_ctrl_pkg::ST_IDLE;
        end
      end
      default: begin
        cur_nxt.st = irq_ctrl_pkg::ST_IDLE;
      end
    endcase

    // return drops the innermost active level
    if (return_from_isr) begin
      sts_set[irq_ctrl_pkg::STS_RETURN] = 1'b1;
      if (cur_r.act_hi) begin
        cur_nxt.act_hi = 1'b0;
      end else begin
        cur_nxt.act_lo = 1'b0;
      end
    end

    // read data captured in setup so it comes out of a flop
    cur_nxt.rdata = 32'h0000_0000;
    cur_nxt.slverr = 1'b0;
    if (psel && !penable) begin
      if (paddr == irq_ctrl_pkg::OFF_ENABLE) begin
        cur_nxt.rdata = {24'h000000, cur_r.en};
      end else if (paddr == irq_ctrl_pkg::OFF_LEVEL) begin
        cur_nxt.rdata = {24'h000000, 1'b1, cur_r.lvl};
      end else if (paddr == irq_ctrl_pkg::OFF_XENABLE) begin
        cur_nxt.rdata = {24'h000000, cur_r.xen & irq_ctrl_pkg::XRSVD_MASK};
      end else if (paddr == irq_ctrl_pkg::OFF_XLEVEL) begin
        cur_nxt.rdata = {24'h000000, cur_r.xlvl & irq_ctrl_pkg::XRSVD_MASK};
      end else if (paddr == irq_ctrl_pkg::OFF_STATUS) begin
        cur_nxt.rdata = {29'h00000000, cur_r.sts};
      end else if (paddr == irq_ctrl_pkg::OFF_MASK) begin
        cur_nxt.rdata = {29'h00000000, cur_r.msk};
      end else if (paddr == irq_ctrl_pkg::OFF_STATE) begin
        cur_nxt.rdata = {22'h000000, cur_r.act_hi, cur_r.act_lo, 2'h0,
                         (cur_r.st == irq_ctrl_pkg::ST_CALL), cur_r.cand_v,
                         cur_r.cand_idx};
      end else begin
        cur_nxt.slverr = 1'b1;
      end
    end

    if (wr_acc) begin
      if (paddr == irq_ctrl_pkg::OFF_ENABLE) begin
        cur_nxt.en = pwdata[7:0];
      end else if (paddr == irq_ctrl_pkg::OFF_LEVEL) begin
        cur_nxt.lvl = pwdata[6:0];
      end else if (paddr == irq_ctrl_pkg::OFF_XENABLE) begin
        cur_nxt.xen = pwdata[7:0] & irq_ctrl_pkg::XRSVD_MASK;
      end else if (paddr == irq_ctrl_pkg::OFF_XLEVEL) begin
        cur_nxt.xlvl = pwdata[7:0] & irq_ctrl_pkg::XRSVD_MASK;
      end else if (paddr == irq_ctrl_pkg::OFF_MASK) begin
        cur_nxt.msk = pwdata[2:0];
      end
    end

    // write-one-clear; a new event in the same cycle wins
    cur_nxt.sts = cur_r.sts;
    if (wr_acc && paddr == irq_ctrl_pkg::OFF_STATUS) begin
      cur_nxt.sts = cur_r.sts & ~pwdata[2:0];
    end
    cur_nxt.sts = cur_nxt.sts | sts_set;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_r.en <= irq_ctrl_pkg::ENABLE_RST;
      cur_r.lvl <= irq_ctrl_pkg::LEVEL_RST;
      cur_r.xen <= irq_ctrl_pkg::XENABLE_RST;
      cur_r.xlvl <= irq_ctrl_pkg::XLEVEL_RST;
      cur_r.sts <= irq_ctrl_pkg::STATUS_RST;
      cur_r.msk <= irq_ctrl_pkg::MASK_RST;
      cur_r.cand_v <= 1'b0;
      cur_r.cand_hi <= 1'b0;
      cur_r.cand_idx <= 4'h0;
      cur_r.st <= irq_ctrl_pkg::ST_IDLE;
      cur_r.cnt <= 2'h0;
      cur_r.act_lo <= 1'b0;
      cur_r.act_hi <= 1'b0;
      cur_r.vec <= irq_ctrl_pkg::VEC_RST;
      cur_r.entry <= 1'b0;
      cur_r.clr <= 15'h0000;
      cur_r.rdata <= 32'h0000_0000;
      cur_r.slverr <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = cur_r.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && cur_r.slverr;
  assign call_busy = (cur_r.st == irq_ctrl_pkg::ST_CALL);
  assign isr_entry = cur_r.entry;
  assign vector_addr = cur_r.vec;
  assign pend_clear = cur_r.clr;
  assign active_level = {cur_r.act_hi, cur_r.act_lo};
  assign irq = |(cur_r.sts & cur_r.msk);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_global_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !cur_r.en[irq_ctrl_pkg::GLOBAL_BIT] |-> !start)
    else $error("call started with global enable low");

  a_call_length: assert property (@(posedge sys_clk) disable iff (rst)
    start |=> call_busy [*4] ##1 !call_busy)
    else $error("call phase not four clocks");

  a_entry_time: assert property (@(posedge sys_clk) disable iff (rst)
    start |-> ##4 isr_entry)
    else $error("entry not four clocks after start");

  a_one_more: assert property (@(posedge sys_clk) disable iff (rst)
    return_from_isr |-> !start)
    else $error("call issued on the return instruction");

  a_vec_slot: assert property (@(posedge sys_clk) disable iff (rst)
    isr_entry |-> (vector_addr[2:0] == 3'h3) && (vector_addr <= irq_ctrl_pkg::VEC_LAST) &&
                  (vector_addr != irq_ctrl_pkg::VEC_BASE + {9'h000, irq_ctrl_pkg::RSVD_IDX,
                  3'h0}))
    else $error("vector outside its slot");

  a_tie_order: assert property (@(posedge sys_clk) disable iff (rst)
    start |-> ((sel_set & lo_mask) == 15'h0000) && (cur_r.cand_hi || !hi_v))
    else $error("lower order source skipped");

  a_auto_clear: assert property (@(posedge sys_clk) disable iff (rst)
    start |=> (pend_clear == (($past(cur_r.cand_idx) <= irq_ctrl_pkg::AUTO_CLR_LAST) ?
               (15'h0001 << $past(cur_r.cand_idx)) : 15'h0000)))
    else $error("wrong pending flag cleared");

  a_hi_locked: assert property (@(posedge sys_clk) disable iff (rst)
    cur_r.act_hi |-> !start)
    else $error("high routine preempted");

  a_lo_blocks: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_r.act_lo && !cur_r.act_hi && !return_from_isr) |=> !(cur_r.cand_v && !cur_r.cand_hi))
    else $error("low request while low routine active");

  a_level_restore: assert property (@(posedge sys_clk) disable iff (rst)
    (return_from_isr && cur_r.act_hi) |=> !cur_r.act_hi && ($past(cur_r.act_lo) == cur_r.act_lo))
    else $error("active level not restored");

  a_sample_each: assert property (@(posedge sys_clk) disable iff (rst)
    (hi_v && hi_ok) |=> cur_r.cand_v && cur_r.cand_hi)
    else $error("request not decoded next clock");

  a_ret_unblock: assert property (@(posedge sys_clk) disable iff (rst)
    (return_from_isr && !cur_r.act_hi && cur_r.act_lo && lo_v && !hi_v) |=>
      cur_r.cand_v && !cur_r.cand_hi)
    else $error("request not ready for the instruction after return");

  a_entry_level: assert property (@(posedge sys_clk) disable iff (rst)
    isr_entry |-> (active_level != 2'b00))
    else $error("routine entered with no active level");

  a_clear_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    (pend_clear != 15'h0000) |=> (pend_clear == 15'h0000))
    else $error("pending clear longer than one clock");

  a_preempt_hi: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_r.act_lo && !cur_r.act_hi && hi_v) |=> cur_r.cand_v && cur_r.cand_hi)
    else $error("high request not taken over low routine");

  a_call_vector: assert property (@(posedge sys_clk) disable iff (rst)
    start |=> (vector_addr[2:0] == 3'h3) &&
              (vector_addr[15:3] == {9'h000, $past(cur_r.cand_idx)}))
    else $error("vector does not match granted source");

  a_global_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !cur_r.en[irq_ctrl_pkg::GLOBAL_BIT] |=> !cur_r.cand_v)
    else $error("candidate kept with global enable low");

endmodule

// [rtl/irq_ctrl_pkg.sv]
// constants, register map and state codes for the vectored interrupt controller
// Function
// - sample and decode requests every clock
// - best response five clocks: detect plus call
// - one instruction runs after return before call
// - worst latency eighteen clocks via core timing
// - equal or higher active level blocks request
// - vectors spaced eight bytes, slot thirteen reserved
// - same level ties resolved by fixed order
// - auto clear external and basic timer flags
// - primary enable at 0xa8, bit7 global
// - per source enable and level bits
// - global enable low blocks every request
// - high preempts low, high never preempted
package irq_ctrl_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 15;
  localparam int IDX_W = 4;
  localparam logic [3:0] RSVD_IDX = 4'hd;
  localparam logic [3:0] AUTO_CLR_LAST = 4'h3;
  localparam logic [1:0] CALL_LAST = 2'h3;
  localparam logic [1:0] ENTRY_SET = 2'h2;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_ENABLE = 8'ha8;
  localparam logic [7:0] OFF_LEVEL = 8'hac;
  localparam logic [7:0] OFF_XENABLE = 8'hb0;
  localparam logic [7:0] OFF_XLEVEL = 8'hb4;
  localparam logic [7:0] OFF_STATUS = 8'hb8;
  localparam logic [7:0] OFF_MASK = 8'hbc;
  localparam logic [7:0] OFF_STATE = 8'hc0;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int GLOBAL_BIT = 7;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [6:0] LEVEL_RST = 7'h00;
  localparam logic [7:0] XENABLE_RST = 8'h00;
  localparam logic [7:0] XLEVEL_RST = 8'h00;
  localparam logic [7:0] XRSVD_MASK = 8'hbf;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam int STS_ENTRY = 0;
  localparam int STS_RETURN = 1;
  localparam int STS_PREEMPT = 2;

  // ---------------------------------------------------------------
  // vectors
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_RST = 16'h0000;
  localparam logic [15:0] VEC_LAST = 16'h0073;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } seq_state_t;

endpackage

// [rtl/prio_pick.sv]
// fixed-order priority picker: lowest index wins
`timescale 1ns/1ps
module prio_pick #(
  parameter int W = 15
) (
  input wire logic [W-1:0] req,
  output logic valid,
  output logic [3:0] idx
);

  always_comb begin
    valid = 1'b0;
    idx = 4'h0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx = 4'(i);
      end
    end
  end

endmodule

// [tb/irq_ctrl_tb_top.sv]
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module irq_ctrl_tb_top;
  typedef struct packed {
    logic [7:0] lat;
    logic [1:0] lvl;
    logic [14:0] clr;
    logic [15:0] vec;
  } note_t;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, instr_done, return_from_isr;
  logic call_busy, isr_entry, irq, ret_go, busy_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [14:0] set_mask, clr_mask, src_pend, pend_clear;
  logic [15:0] vector_addr;
  logic [1:0] active_level;
  logic [32:0] rd_exp;
  logic [32:0] rd_q[$];
  note_t nq[$];
  note_t cur;
  int mismatches, compares, since, cyc;

  irq_ctrl irq_ctrl_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_pend(src_pend), .instr_done(instr_done),
    .return_from_isr(return_from_isr), .call_busy(call_busy), .isr_entry(isr_entry),
    .vector_addr(vector_addr), .pend_clear(pend_clear), .active_level(active_level), .irq(irq));
  irq_partner irq_partner_i (.sys_clk(sys_clk), .rst(rst), .call_busy(call_busy),
    .ret_go(ret_go), .set_mask(set_mask), .clr_mask(clr_mask), .pend_clear(pend_clear),
    .instr_done(instr_done), .return_from_isr(return_from_isr), .src_pend(src_pend));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic note_t nt(input int lat, input logic [1:0] lvl, input int i);
    note_t n;
    n.lat = 8'(lat);
    n.lvl = lvl;
    n.clr = (i < 4) ? 15'(1 << i) : 15'h0000;
    n.vec = irq_ctrl_pkg::VEC_BASE + 16'(8 * i);
    return n;
  endfunction
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) rd_q.push_back(e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait limit here: only the bench timeout ends a stuck access
    do begin
      @(posedge sys_clk);
    end while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [14:0] m, input logic clr);
    @(posedge sys_clk);
    if (clr) clr_mask <= m;
    else set_mask <= m;
    @(posedge sys_clk);
    clr_mask <= 15'h0000;
    set_mask <= 15'h0000;
  endtask
  task automatic wait_entry;
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (!isr_entry && k < 60);
    check("entry seen", {31'h0, isr_entry}, 32'h1);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic ret;
    @(posedge sys_clk);
    ret_go <= 1'b1;
    @(posedge sys_clk);
    ret_go <= 1'b0;
    repeat (22) @(posedge sys_clk);
  endtask
  task automatic chk_irq(input logic e);
    @(posedge sys_clk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // ---------------------------------------------------------------
  // monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run;
    end
    busy_q <= call_busy;
    since <= (set_mask != 15'h0000) ? 0 : since + 1;
    if (psel && penable && !pwrite && pready && rd_q.size() != 0) begin
      rd_exp = rd_q.pop_front();
      check("prdata", prdata, rd_exp[31:0]);
      check("pslverr", {31'h0, pslverr}, {31'h0, rd_exp[32]});
    end
    if (call_busy && !busy_q) begin
      cur = (nq.size() != 0) ? nq[0] : '1;
      check("vector", {16'h0, vector_addr}, {16'h0, cur.vec});
      check("clear", {17'h0, pend_clear}, {17'h0, cur.clr});
    end
    if (isr_entry && nq.size() != 0) begin
      cur = nq.pop_front();
      if (cur.lat != 8'h00) check("latency", since, {24'h0, cur.lat});
      check("level", {30'h0, active_level}, {30'h0, cur.lvl});
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, set_mask, clr_mask, ret_go} = '0;
    rst = 1'b1;
    {mismatches, compares, since, cyc} = '0;
    rnd = 32'hcb2e;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    apb(irq_ctrl_pkg::OFF_ENABLE, 1'b0, 32'h0, 33'h0);
    apb(irq_ctrl_pkg::OFF_LEVEL, 1'b0, 32'h0, 33'h80);
    apb(irq_ctrl_pkg::OFF_STATUS, 1'b0, 32'h0, 33'h0);
    apb(irq_ctrl_pkg::OFF_MASK, 1'b0, 32'h0, 33'h0);
    apb(8'h04, 1'b0, 32'h0, {1'b1, 32'h0});
    rnd = xs(rnd);
    apb(irq_ctrl_pkg::OFF_XENABLE, 1'b1, rnd, 33'h0);
    apb(irq_ctrl_pkg::OFF_XENABLE, 1'b0, 32'h0, {25'h0, rnd[7:0] & irq_ctrl_pkg::XRSVD_MASK});
    apb(irq_ctrl_pkg::OFF_ENABLE, 1'b1, 32'h7f, 33'h0);
    apb(irq_ctrl_pkg::OFF_ENABLE, 1'b0, 32'h0, 33'h7f);
    $display("test registers done");
    apb(irq_ctrl_pkg::OFF_MASK, 1'b1, 32'h1, 33'h0);
    nq.push_back(nt(0, 2'b01, 0));
    pulse(15'h0001, 1'b0);
    repeat (10) @(posedge sys_clk);
    check("blocked", {31'h0, call_busy}, 32'h0);
    apb(irq_ctrl_pkg::OFF_ENABLE, 1'b1, 32'h81, 33'h0);
    wait_entry;
    chk_irq(1'b1);
    apb(irq_ctrl_pkg::OFF_MASK, 1'b1, 32'h0, 33'h0);
    chk_irq(1'b0);
    apb(irq_ctrl_pkg::OFF_MASK, 1'b1, 32'h1, 33'h0);
    apb(irq_ctrl_pkg::OFF_STATUS, 1'b1, 32'h7, 33'h0);
    chk_irq(1'b0);
    ret;
    apb(irq_ctrl_pkg::OFF_STATUS, 1'b0, 32'h0, 33'h2);
    $display("test global enable and status done");
    apb(irq_ctrl_pkg::OFF_ENABLE, 1'b1, 32'hff, 33'h0);
    apb(irq_ctrl_pkg::OFF_XENABLE, 1'b1, 32'hbf, 33'h0);
    for (int i = 0; i < 15; i++) begin
      if (i != 13) begin
        nq.push_back(nt(5, 2'b01, i));
        pulse(15'h5fff & ~15'((1 << i) - 1), 1'b0);
        wait_entry;
        pulse(15'h7fff, 1'b1);
        ret;
      end
    end
    $display("test vectors and order done");
    apb(irq_ctrl_pkg::OFF_STATUS, 1'b1, 32'h7, 33'h0);
    apb(irq_ctrl_pkg::OFF_LEVEL, 1'b1, 32'h06, 33'h0);
    nq.push_back(nt(5, 2'b01, 4));
    pulse(15'h0010, 1'b0);
    wait_entry;
    pulse(15'h0010, 1'b1);
    nq.push_back(nt(5, 2'b11, 1));
    pulse(15'h0002, 1'b0);
    wait_entry;
    apb(irq_ctrl_pkg::OFF_STATUS, 1'b0, 32'h0, 33'h5);
    nq.push_back(nt(0, 2'b11, 2));
    nq.push_back(nt(0, 2'b01, 0));
    pulse(15'h0005, 1'b0);
    repeat (10) @(posedge sys_clk);
    check("no preempt", {31'h0, call_busy}, 32'h0);
    apb(irq_ctrl_pkg::OFF_STATE, 1'b0, 32'h0, 33'h300);
    repeat (4) ret;
    check("idle level", {30'h0, active_level}, 32'h0);
    $display("test preemption done");
    apb(irq_ctrl_pkg::OFF_LEVEL, 1'b1, 32'h0, 33'h0);
    nq.push_back(nt(5, 2'b01, 0));
    pulse(15'h0001, 1'b0);
    wait_entry;
    nq.push_back(nt(18, 2'b01, 1));
    pulse(15'h0002, 1'b0);
    @(posedge sys_clk);
    ret_go <= 1'b1;
    @(posedge sys_clk);
    ret_go <= 1'b0;
    wait_entry;
    ret;
    $display("test worst latency done");
    check("notes left", nq.size(), 32'h0);
    complete_run;
  end
endmodule

// [tb/irq_partner.sv]
// core sequencer and peripheral flag stand-in for the interrupt controller bench
`timescale 1ns/1ps
module irq_partner (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic call_busy,
  input wire logic ret_go,
  input wire logic [14:0] set_mask,
  input wire logic [14:0] clr_mask,
  input wire logic [14:0] pend_clear,
  output logic instr_done,
  output logic return_from_isr,
  output logic [14:0] src_pend
);
  // ---------------------------------------------------------------
  // instruction timing and pending flags
  // ---------------------------------------------------------------
  logic [3:0] cnt_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      src_pend <= 15'h0000;
    end else begin
      // return of 5 clocks, then an 8 clock divide
      if (ret_go) begin
        cnt_r <= 4'hd;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
      // software clear and hardware clear both drop a flag
      src_pend <= (src_pend & ~pend_clear & ~clr_mask) | set_mask;
    end
  end
  // no boundary while the call runs, else single-cycle instructions outside the return and divide counts
  assign instr_done = !rst && ((cnt_r == 4'h0) ? !call_busy : (cnt_r == 4'h9 || cnt_r == 4'h1));
  assign return_from_isr = !rst && cnt_r == 4'h9;
endmodule
